//--- core/ufc_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the flow-control and FIFO-level block.
// Assumes byte addresses on an 8-bit AXI4-Lite address.
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH
`define UFC_OFS_EFR 8'h00
`define UFC_OFS_IER 8'h04
`define UFC_OFS_ISR 8'h08
`define UFC_OFS_FCR 8'h0c
`define UFC_OFS_MCR 8'h10
`define UFC_OFS_FEATURE_CTRL_REG 8'h14
`define UFC_OFS_TX_FIFO_LEVEL_COUNT 8'h18
`define UFC_OFS_TX_FIFO_TRIGGER_LEVEL 8'h1c
`define UFC_OFS_RX_FIFO_LEVEL_COUNT 8'h20
`define UFC_OFS_RXTRG 8'h24
`define UFC_OFS_RES1 8'h28
`define UFC_OFS_RES2 8'h2c
`define UFC_OFS_STP1 8'h30
`define UFC_OFS_STP2 8'h34
`define UFC_RST_BYTE 8'h00
`define UFC_FIFO_MAX 8'h40
`define UFC_LVL_1 8'h08
`define UFC_LVL_2 8'h10
`define UFC_LVL_3 8'h38
`define UFC_LVL_4 8'h3c
`define UFC_STOP_DLY_CHARS 2
`define UFC_EFR_ENH 4
`define UFC_EFR_SPC 5
`define UFC_EFR_ARTS 6
`define UFC_EFR_ACTS 7
`define UFC_MCR_DTR 0
`define UFC_MCR_RTS 1
`define UFC_MCR_PSEL 2
`define UFC_ISR_STOP 4
`define UFC_ISR_HWFC 5
`define UFC_RESP_OK 2'h0
`define UFC_RESP_ERR 2'h2
`endif

//--- core/ufc_pkg.sv
// Types shared by the flow-control block: sender states and the
// whole register state of the block as one packed struct.
package ufc_pkg;
    typedef enum logic [1:0] {FC_IDLE, FC_WAIT, FC_SEND_A, FC_SEND_B} ufc_fc_st_t;
    typedef struct packed {
        logic [7:0] enhanced_feature_control;
        logic [7:0] int_enable_reg;
        logic [1:0] int_status_reg;
        logic [7:0] fifo_ctrl_reg;
        logic [7:0] modem_ctrl_reg;
        logic [7:0] feature_ctrl_reg;
        logic [7:0] tx_trig;
        logic [7:0] rx_trig;
        logic [7:0] res1;
        logic [7:0] res2;
        logic [7:0] stp1;
        logic [7:0] stp2;
        logic [7:0] tx_cnt;
        logic [7:0] rx_cnt;
        ufc_fc_st_t fc_st;
        logic fc_stop;
        logic [15:0] fc_tmr;
        logic [7:0] fc_data;
        logic stop_sent;
        logic rx_halt;
        logic half_stop;
        logic half_res;
        logic rts_hold;
        logic rx_store;
        logic [7:0] rx_data;
        logic [1:0] cts_sync;
        logic [1:0] dsr_sync;
        logic aw_ok;
        logic [7:0] awaddr;
        logic w_ok;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ufc_state_t;
endpackage

//--- core/ufc_top.sv
// Flow-control and FIFO-level logic of one UART channel.
// Assumes a line shifter on the same clock that hands in received
// characters and takes flow characters, and FIFOs that report pushes
// and pops. Modem pins come from outside and are synchronised here.
`include "ufc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ufc_top #(
    parameter int P_CHAR_CYC = 1250
) (
    input wire logic I_CLK_SYS,
    input wire logic I_SYS_RST,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [7:0] I_ARADDR,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    input wire logic I_TX_PUSH,
    input wire logic I_TX_POP,
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_DATA,
    input wire logic I_RX_POP,
    output logic O_RX_STORE,
    output logic [7:0] O_RX_STORE_DATA,
    output logic O_FC_VALID,
    input wire logic I_FC_READY,
    output logic [7:0] O_FC_DATA,
    output logic O_TX_HALT,
    output logic O_TX_BELOW_TRIG,
    output logic O_RX_AT_TRIG,
    input wire logic I_CTS_N,
    input wire logic I_DSR_N,
    output logic O_RTS_N,
    output logic O_DTR_N
);
    localparam logic [15:0] STOP_DLY_CYC =
        16'(`UFC_STOP_DLY_CHARS * P_CHAR_CYC - 1);

    ufc_pkg::ufc_state_t st_reg;
    ufc_pkg::ufc_state_t st_next;
    logic [7:0] hyst;
    logic [7:0] lvl_up;
    logic [7:0] lvl_dn;
    logic [1:0] tx_sel;
    logic [1:0] rx_sel;
    logic m_s1, m_s2, m_r1, m_r2;
    logic is_stop, is_res, consume, special;
    logic clr_in_hi;

    // Hysteresis steps of table D, indexed by the select field
    always_comb begin
        case (st_reg.feature_ctrl_reg[3:0])
            4'h0: hyst = 8'h00;
            4'h1: hyst = 8'h04;
            4'h2: hyst = 8'h06;
            4'h3: hyst = 8'h08;
            4'h4: hyst = 8'h08;
            4'h5: hyst = 8'h10;
            4'h6: hyst = 8'h18;
            4'h7: hyst = 8'h20;
            4'h8: hyst = 8'h28;
            4'h9: hyst = 8'h2c;
            4'ha: hyst = 8'h30;
            4'hb: hyst = 8'h34;
            4'hc: hyst = 8'h0c;
            4'hd: hyst = 8'h14;
            4'he: hyst = 8'h1c;
            default: hyst = 8'h24;
        endcase
    end

    // Upper and lower switch levels around the receive trigger
    always_comb begin
        if (st_reg.feature_ctrl_reg[7:6] == 2'h3 && hyst != 8'h00) begin
            lvl_up = (st_reg.rx_trig + hyst > `UFC_FIFO_MAX) ?
                `UFC_FIFO_MAX : 8'(st_reg.rx_trig + hyst);
            lvl_dn = (hyst > st_reg.rx_trig) ? 8'h00 :
                8'(st_reg.rx_trig - hyst);
        end else begin
            // Neighbour levels of the trigger list
            if (st_reg.rx_trig < `UFC_LVL_1) lvl_up = `UFC_LVL_1;
            else if (st_reg.rx_trig < `UFC_LVL_2) lvl_up = `UFC_LVL_2;
            else if (st_reg.rx_trig < `UFC_LVL_3) lvl_up = `UFC_LVL_3;
            else if (st_reg.rx_trig < `UFC_LVL_4) lvl_up = `UFC_LVL_4;
            else lvl_up = `UFC_FIFO_MAX;
            if (st_reg.rx_trig > `UFC_LVL_4) lvl_dn = `UFC_LVL_4;
            else if (st_reg.rx_trig > `UFC_LVL_3) lvl_dn = `UFC_LVL_3;
            else if (st_reg.rx_trig > `UFC_LVL_2) lvl_dn = `UFC_LVL_2;
            else if (st_reg.rx_trig > `UFC_LVL_1) lvl_dn = `UFC_LVL_1;
            else lvl_dn = 8'h00;
        end
    end

    // Receive comparison of flow and special characters
    always_comb begin
        tx_sel = st_reg.enhanced_feature_control[3:2];
        rx_sel = st_reg.enhanced_feature_control[1:0];
        m_s1 = I_RX_DATA == st_reg.stp1;
        m_s2 = I_RX_DATA == st_reg.stp2;
        m_r1 = I_RX_DATA == st_reg.res1;
        m_r2 = I_RX_DATA == st_reg.res2;
        is_stop = 1'b0;
        is_res = 1'b0;
        case (rx_sel)
            2'h1: begin
                is_stop = m_s2;
                is_res = m_r2;
            end
            2'h2: begin
                is_stop = m_s1;
                is_res = m_r1;
            end
            2'h3: begin
                if (tx_sel == 2'h1 || tx_sel == 2'h2) begin
                    is_stop = m_s1 | m_s2;
                    is_res = m_r1 | m_r2;
                end else begin
                    is_stop = st_reg.half_stop & m_s2;
                    is_res = st_reg.half_res & m_r2;
                end
            end
            default: ;
        endcase
        consume = is_stop | is_res;
        // Pair 2 compare swallows stop_char_2 even when special
        special = st_reg.enhanced_feature_control[`UFC_EFR_SPC] & m_s2;
    end

    // Selected clear input; the second sync stage only is read
    assign clr_in_hi = st_reg.modem_ctrl_reg[`UFC_MCR_PSEL] ?
        st_reg.dsr_sync[1] : st_reg.cts_sync[1];

    // Next state of everything
    always_comb begin
        st_next = st_reg;
        st_next.rx_store = 1'b0;
        st_next.cts_sync = {st_reg.cts_sync[0], I_CTS_N};
        st_next.dsr_sync = {st_reg.dsr_sync[0], I_DSR_N};

        // Bus address and data are taken in either order
        if (I_AWVALID && !st_reg.aw_ok) begin
            st_next.aw_ok = 1'b1;
            st_next.awaddr = I_AWADDR;
        end
        if (I_WVALID && !st_reg.w_ok) begin
            st_next.w_ok = 1'b1;
            st_next.wdata = I_WDATA[7:0];
            st_next.wstrb0 = I_WSTRB[0];
        end
        if (st_reg.bvalid && I_BREADY) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid) begin
            st_next.aw_ok = 1'b0;
            st_next.w_ok = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `UFC_RESP_OK;
            if (st_reg.wstrb0) begin
                case (st_reg.awaddr)
                    `UFC_OFS_EFR: st_next.enhanced_feature_control = st_reg.wdata;
                    `UFC_OFS_IER: begin
                        st_next.int_enable_reg[3:0] = st_reg.wdata[3:0];
                        if (st_reg.enhanced_feature_control[`UFC_EFR_ENH]) begin
                            st_next.int_enable_reg[7:4] = st_reg.wdata[7:4];
                        end
                    end
                    `UFC_OFS_ISR: begin
                        if (st_reg.enhanced_feature_control[`UFC_EFR_ENH]) begin
                            st_next.int_status_reg = st_reg.int_status_reg & ~st_reg.wdata[5:4];
                        end
                    end
                    `UFC_OFS_FCR: begin
                        st_next.fifo_ctrl_reg[3:0] = st_reg.wdata[3:0];
                        st_next.fifo_ctrl_reg[7:6] = st_reg.wdata[7:6];
                        if (st_reg.enhanced_feature_control[`UFC_EFR_ENH]) begin
                            st_next.fifo_ctrl_reg[5:4] = st_reg.wdata[5:4];
                        end
                    end
                    `UFC_OFS_MCR: begin
                        st_next.modem_ctrl_reg[4:0] = st_reg.wdata[4:0];
                        if (st_reg.enhanced_feature_control[`UFC_EFR_ENH]) begin
                            st_next.modem_ctrl_reg[7:5] = st_reg.wdata[7:5];
                        end
                    end
                    `UFC_OFS_FEATURE_CTRL_REG: st_next.feature_ctrl_reg = st_reg.wdata;
                    `UFC_OFS_TX_FIFO_TRIGGER_LEVEL: st_next.tx_trig = st_reg.wdata;
                    `UFC_OFS_RXTRG: st_next.rx_trig = st_reg.wdata;
                    `UFC_OFS_RES1: st_next.res1 = st_reg.wdata;
                    `UFC_OFS_RES2: st_next.res2 = st_reg.wdata;
                    `UFC_OFS_STP1: st_next.stp1 = st_reg.wdata;
                    `UFC_OFS_STP2: st_next.stp2 = st_reg.wdata;
                    `UFC_OFS_TX_FIFO_LEVEL_COUNT, `UFC_OFS_RX_FIFO_LEVEL_COUNT: ;
                    default: st_next.bresp = `UFC_RESP_ERR;
                endcase
            end
        end

        // Read channel: one answer at a time, data from flops
        if (st_reg.rvalid && I_RREADY) begin
            st_next.rvalid = 1'b0;
        end
        if (I_ARVALID && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `UFC_RESP_OK;
            st_next.rdata = 32'h0;
            case (I_ARADDR)
                `UFC_OFS_EFR: st_next.rdata[7:0] = st_reg.enhanced_feature_control;
                `UFC_OFS_IER: st_next.rdata[7:0] = st_reg.int_enable_reg;
                `UFC_OFS_ISR: st_next.rdata[5:4] = st_reg.int_status_reg;
                `UFC_OFS_FCR: st_next.rdata[7:0] = st_reg.fifo_ctrl_reg;
                `UFC_OFS_MCR: st_next.rdata[7:0] = st_reg.modem_ctrl_reg;
                `UFC_OFS_FEATURE_CTRL_REG: st_next.rdata[7:0] = st_reg.feature_ctrl_reg;
                `UFC_OFS_TX_FIFO_LEVEL_COUNT: st_next.rdata[7:0] = st_reg.tx_cnt;
                `UFC_OFS_RX_FIFO_LEVEL_COUNT: st_next.rdata[7:0] = st_reg.rx_cnt;
                `UFC_OFS_RXTRG: st_next.rdata[7:0] = st_reg.rx_trig;
                `UFC_OFS_RES1: st_next.rdata[7:0] = st_reg.res1;
                `UFC_OFS_RES2: st_next.rdata[7:0] = st_reg.res2;
                `UFC_OFS_STP1: st_next.rdata[7:0] = st_reg.stp1;
                `UFC_OFS_STP2: st_next.rdata[7:0] = st_reg.stp2;
                `UFC_OFS_TX_FIFO_TRIGGER_LEVEL: ; // Write-only, reads zero
                default: st_next.rresp = `UFC_RESP_ERR;
            endcase
        end

        // Transmit level follows pushes and pops, held to 0..64
        if (I_TX_PUSH && !I_TX_POP && st_reg.tx_cnt < `UFC_FIFO_MAX) begin
            st_next.tx_cnt = st_reg.tx_cnt + 8'h01;
        end else if (I_TX_POP && !I_TX_PUSH && st_reg.tx_cnt != 8'h00) begin
            st_next.tx_cnt = st_reg.tx_cnt - 8'h01;
        end

        // Received characters: flow chars are consumed, rest stored while the level is below 64
        st_next.rx_cnt = (I_RX_POP && st_reg.rx_cnt != 8'h00) ?
            st_reg.rx_cnt - 8'h01 : st_reg.rx_cnt;
        if (I_RX_VALID) begin
            st_next.half_stop = m_s1;
            st_next.half_res = m_r1;
            if (is_stop) st_next.rx_halt = 1'b1;
            if (is_res) st_next.rx_halt = 1'b0;
            if (!consume && st_next.rx_cnt < `UFC_FIFO_MAX) begin
                st_next.rx_store = 1'b1;
                st_next.rx_data = I_RX_DATA;
                st_next.rx_cnt = st_next.rx_cnt + 8'h01;
            end
            // Hardware set wins over a clear in the same cycle
            if (is_stop || special) begin
                st_next.int_status_reg[0] = 1'b1;
            end
        end
        if (rx_sel == 2'h0) begin
            st_next.rx_halt = 1'b0;
        end

        // Auto request hold: upper level sets, lower level clears
        if (!st_reg.enhanced_feature_control[`UFC_EFR_ARTS]) begin
            st_next.rts_hold = 1'b0;
        end else if (st_reg.rx_cnt >= lvl_up) begin
            st_next.rts_hold = 1'b1;
        end else if (st_reg.rx_cnt < lvl_dn) begin
            st_next.rts_hold = 1'b0;
        end
        if (st_next.rts_hold != st_reg.rts_hold) begin
            st_next.int_status_reg[1] = 1'b1;
        end

        // Flow character sender
        case (st_reg.fc_st)
            ufc_pkg::FC_IDLE: begin
                if (tx_sel == 2'h0) begin
                    st_next.stop_sent = 1'b0;
                end else if (!st_reg.stop_sent && st_reg.rx_cnt >= st_reg.rx_trig) begin
                    st_next.fc_st = ufc_pkg::FC_WAIT;
                    st_next.fc_tmr = 16'h0000;
                end else if (st_reg.stop_sent && st_reg.rx_cnt < lvl_dn) begin
                    st_next.fc_st = ufc_pkg::FC_SEND_A;
                    st_next.fc_stop = 1'b0;
                    st_next.fc_data = (tx_sel == 2'h1) ? st_reg.res2 : st_reg.res1;
                end
            end
            ufc_pkg::FC_WAIT: begin
                st_next.fc_tmr = st_reg.fc_tmr + 16'h0001;
                if (tx_sel == 2'h0) begin
                    st_next.fc_st = ufc_pkg::FC_IDLE;
                end else if (st_reg.fc_tmr >= STOP_DLY_CYC) begin
                    st_next.fc_st = ufc_pkg::FC_SEND_A;
                    st_next.fc_stop = 1'b1;
                    st_next.fc_data = (tx_sel == 2'h1) ? st_reg.stp2 : st_reg.stp1;
                end
            end
            ufc_pkg::FC_SEND_A: begin
                if (I_FC_READY) begin
                    st_next.stop_sent = st_reg.fc_stop;
                    if (tx_sel == 2'h3) begin
                        // Second char follows at once, nothing between
                        st_next.fc_st = ufc_pkg::FC_SEND_B;
                        st_next.fc_data = st_reg.fc_stop ? st_reg.stp2 : st_reg.res2;
                    end else begin
                        st_next.fc_st = ufc_pkg::FC_IDLE;
                    end
                end
            end
            ufc_pkg::FC_SEND_B: begin
                if (I_FC_READY) begin
                    st_next.fc_st = ufc_pkg::FC_IDLE;
                end
            end
            default: st_next.fc_st = ufc_pkg::FC_IDLE;
        endcase
    end

    // Single register for all state; reset gives a legacy UART
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus handshakes are combinational, answers come from flops
    assign O_AWREADY = !st_reg.aw_ok;
    assign O_WREADY = !st_reg.w_ok;
    assign O_BVALID = st_reg.bvalid;
    assign O_BRESP = st_reg.bresp;
    assign O_ARREADY = !st_reg.rvalid;
    assign O_RVALID = st_reg.rvalid;
    assign O_RDATA = st_reg.rdata;
    assign O_RRESP = st_reg.rresp;
    assign O_RX_STORE = st_reg.rx_store;
    assign O_RX_STORE_DATA = st_reg.rx_data;
    assign O_FC_VALID = st_reg.fc_st == ufc_pkg::FC_SEND_A ||
        st_reg.fc_st == ufc_pkg::FC_SEND_B;
    assign O_FC_DATA = st_reg.fc_data;

    // Level flags; tx compares strictly below so trigger 0 never fires it, rx compares at-or-above so trigger 0 always fires
    assign O_TX_BELOW_TRIG = st_reg.tx_cnt < st_reg.tx_trig;
    assign O_RX_AT_TRIG = st_reg.rx_cnt >= st_reg.rx_trig;

    // Halt the transmitter on received stop or on clear input high
    assign O_TX_HALT = st_reg.rx_halt |
        (st_reg.enhanced_feature_control[`UFC_EFR_ACTS] & clr_in_hi);

    // Pins: hold only adds on top of the software request
    assign O_RTS_N = !st_reg.modem_ctrl_reg[`UFC_MCR_RTS] |
        (st_reg.rts_hold & !st_reg.modem_ctrl_reg[`UFC_MCR_PSEL]);
    assign O_DTR_N = !st_reg.modem_ctrl_reg[`UFC_MCR_DTR] |
        (st_reg.rts_hold & st_reg.modem_ctrl_reg[`UFC_MCR_PSEL]);

    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);

    // Checks on the block's own behaviour
    a_rx_level_max: assert property (st_reg.rx_cnt <= `UFC_FIFO_MAX)
        else $error("rx level above 64");
    a_tx_level_max: assert property (st_reg.tx_cnt <= `UFC_FIFO_MAX)
        else $error("tx level above 64");
    a_ier_frozen: assert property (!st_reg.enhanced_feature_control[`UFC_EFR_ENH] |=> $stable(st_reg.int_enable_reg[7:4]))
        else $error("protected ier bits changed while locked");
    a_mcr_frozen: assert property (!st_reg.enhanced_feature_control[`UFC_EFR_ENH] |=> $stable(st_reg.modem_ctrl_reg[7:5]))
        else $error("protected mcr bits changed while locked");
    a_stop_delay: assert property ($rose(st_reg.fc_st == ufc_pkg::FC_WAIT) |->
        (st_reg.fc_st == ufc_pkg::FC_WAIT)[*4])
        else $error("stop char sent too soon");
    a_request_gpo: assert property (!st_reg.enhanced_feature_control[`UFC_EFR_ARTS] |->
        O_RTS_N == !st_reg.modem_ctrl_reg[`UFC_MCR_RTS])
        else $error("request pin not following modem control");
    a_request_hold: assert property (st_reg.enhanced_feature_control[`UFC_EFR_ARTS] && st_reg.rx_cnt >= lvl_up
        && st_reg.modem_ctrl_reg[`UFC_MCR_PSEL] == 1'b0 |=> O_RTS_N)
        else $error("request pin not deasserted at upper level");
    a_clear_halt: assert property (st_reg.enhanced_feature_control[`UFC_EFR_ACTS] && !st_reg.modem_ctrl_reg[`UFC_MCR_PSEL]
        && st_reg.cts_sync[1] |-> O_TX_HALT)
        else $error("transmitter not halted by clear input");
    a_special_kept: assert property (I_RX_VALID && special && !consume
        && st_reg.rx_cnt < 8'h3f |=> O_RX_STORE && st_reg.int_status_reg[0])
        else $error("special char not stored or flagged");
    a_reset_legacy: assert property (disable iff (1'b0) $past(I_SYS_RST) |->
        st_reg.enhanced_feature_control == 8'h00 && st_reg.int_enable_reg == 8'h00 && st_reg.modem_ctrl_reg == 8'h00)
        else $error("enhanced bits not cleared by reset");

    c_stop_sent: cover property (st_reg.fc_st == ufc_pkg::FC_SEND_A && st_reg.fc_stop);
    c_resume_sent: cover property (st_reg.fc_st == ufc_pkg::FC_SEND_A && !st_reg.fc_stop);
    c_pair_sent: cover property (st_reg.fc_st == ufc_pkg::FC_SEND_B);
    c_hold_rise: cover property ($rose(st_reg.rts_hold));
endmodule
`default_nettype wire

//--- bench/ufc_peer.sv
// Remote serial device model: takes flow characters, sends received ones.
// Assumes the block's line-side handshake runs on the block's clock.
`timescale 1ns/1ps
`default_nettype none
module ufc_peer (
    input wire logic i_clk,
    input wire logic i_fc_valid,
    input wire logic [7:0] i_fc_data,
    output logic o_fc_ready,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data
);
    logic [7:0] got[$];
    logic [1:0] pace = 2'h0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
    end
    // Ready one cycle in four, so the sender has to hold its character
    always_comb o_fc_ready = (pace == 2'h3);
    always @(posedge i_clk) begin
        pace <= pace + 2'h1;
        if (i_fc_valid && o_fc_ready) got.push_back(i_fc_data);
    end
    // One character; the data line shows the inverse once it is over
    task automatic send(input logic [7:0] c);
        @(posedge i_clk);
        o_rx_valid <= 1'b1;
        o_rx_data <= c;
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~c;
    endtask
endmodule
`default_nettype wire

//--- bench/ufc_top_tb.sv
// Self-checking bench: register tasks over AXI4-Lite and line traffic.
// Assumes the peer model on the line side and a short character time.
`include "ufc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ufc_top_tb;
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic push = 1'b0, tpop = 1'b0, rpop = 1'b0, cts = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, rxd;
    logic [31:0] wd = 32'h0, rdat;
    logic awr, wr_ok, bv, arr, rv, rxv, fcv, fifo_ctrl_reg, halt, below, rts_n, dtr_n;
    logic [1:0] rr, br, last_br;
    logic attrig;
    logic [7:0] fcd;
    int bad_count = 0;
    int tests_run = 0;
    ufc_top #(.P_CHAR_CYC(4)) dut (.I_CLK_SYS(clk), .I_SYS_RST(rst),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr_ok),
        .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(brdy), .O_BRESP(br),
        .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rrdy),
        .O_RDATA(rdat), .O_RRESP(rr), .I_TX_PUSH(push), .I_TX_POP(tpop), .I_RX_VALID(rxv),
        .I_RX_DATA(rxd), .I_RX_POP(rpop), .O_RX_STORE(), .O_RX_STORE_DATA(), .O_FC_VALID(fcv),
        .I_FC_READY(fifo_ctrl_reg), .O_FC_DATA(fcd), .O_TX_HALT(halt), .O_TX_BELOW_TRIG(below),
        .O_RX_AT_TRIG(attrig), .I_CTS_N(cts), .I_DSR_N(1'b0), .O_RTS_N(rts_n),
        .O_DTR_N(dtr_n));
    ufc_peer peer (.i_clk(clk), .i_fc_valid(fcv), .i_fc_data(fcd), .o_fc_ready(fifo_ctrl_reg),
        .o_rx_valid(rxv), .o_rx_data(rxd));
    initial forever #4 clk = ~clk;
    task automatic test_done();
        $display("Counts: %0d compared, %0d bad", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        $display("BAD %0t wait ran out", $time);
        test_done();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        awv <= 1'b1; wv <= 1'b1; awa <= a; wd <= {24'h0, d}; brdy <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_ok) wv <= 1'b0;
            // Response code is taken at the edge that sees valid high
            if (bv) begin
                last_br = br;
                break;
            end
        end
        brdy <= 1'b0;
        if (n == 50) hang();
    endtask
    task automatic rdx(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        arv <= 1'b1; ara <= a; rrdy <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        d = rdat;
        r = rr;
        rrdy <= 1'b0;
        if (n == 50) hang();
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rdx(a, d, r);
        chk(d, {24'h0, e});
    endtask
    // Pulses on tx push (0), tx pop (1) or rx pop (2), a cycle apart
    task automatic pulse(input int k, input int s);
        repeat (k) begin
            @(posedge clk);
            if (s == 0) push <= 1'b1; else if (s == 1) tpop <= 1'b1; else rpop <= 1'b1;
            @(posedge clk);
            push <= 1'b0; tpop <= 1'b0; rpop <= 1'b0;
        end
    endtask
    task automatic wait_fc(input int k);
        for (int n = 0; n < 200 && peer.got.size() < k; n++) @(posedge clk);
        if (peer.got.size() < k) hang();
    endtask
    initial begin : main
        logic [31:0] d;
        logic [1:0] r;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`UFC_OFS_EFR, 8'h00);
        rd_chk(`UFC_OFS_IER, 8'h00);
        rd_chk(`UFC_OFS_MCR, 8'h00);
        rd_chk(`UFC_OFS_TX_FIFO_LEVEL_COUNT, 8'h00);
        rd_chk(`UFC_OFS_RX_FIFO_LEVEL_COUNT, 8'h00);
        chk({31'h0, rts_n}, 32'h1);
        rdx(8'h3c, d, r);
        chk({30'h0, r}, {30'h0, `UFC_RESP_ERR});
        chk({31'h0, attrig}, 32'h1);
        wr(8'h3c, 8'h00);
        chk({30'h0, last_br}, {30'h0, `UFC_RESP_ERR});
        $display("test reset done");
        // Enhanced bits held back while the gate is shut
        wr(`UFC_OFS_IER, 8'hf0);
        chk({30'h0, last_br}, {30'h0, `UFC_RESP_OK});
        rd_chk(`UFC_OFS_IER, 8'h00);
        wr(`UFC_OFS_EFR, 8'h10);
        wr(`UFC_OFS_IER, 8'hf0);
        rd_chk(`UFC_OFS_IER, 8'hf0);
        wr(`UFC_OFS_EFR, 8'h00);
        wr(`UFC_OFS_IER, 8'h00);
        rd_chk(`UFC_OFS_IER, 8'hf0);
        $display("test gate done");
        wr(`UFC_OFS_TX_FIFO_TRIGGER_LEVEL, 8'h02);
        rd_chk(`UFC_OFS_TX_FIFO_TRIGGER_LEVEL, 8'h00);
        pulse(3, 0);
        rd_chk(`UFC_OFS_TX_FIFO_LEVEL_COUNT, 8'h03);
        chk({31'h0, below}, 32'h0);
        pulse(2, 1);
        rd_chk(`UFC_OFS_TX_FIFO_LEVEL_COUNT, 8'h01);
        chk({31'h0, below}, 32'h1);
        $display("test tx level done");
        // Both pairs sent, auto request and auto clear on, trigger 16
        wr(`UFC_OFS_STP1, 8'h13);
        wr(`UFC_OFS_STP2, 8'h93);
        wr(`UFC_OFS_RES1, 8'h11);
        wr(`UFC_OFS_RES2, 8'h91);
        wr(`UFC_OFS_RXTRG, 8'h10);
        chk({31'h0, attrig}, 32'h0);
        wr(`UFC_OFS_MCR, 8'h02);
        wr(`UFC_OFS_EFR, 8'hdc);
        chk({31'h0, rts_n}, 32'h0);
        repeat (16) peer.send(8'h41);
        wait_fc(2);
        chk({31'h0, attrig}, 32'h1);
        chk({24'h0, peer.got[0]}, 32'h13);
        chk({24'h0, peer.got[1]}, 32'h93);
        repeat (39) peer.send(8'h42);
        repeat (3) @(posedge clk);
        chk({31'h0, rts_n}, 32'h0);
        peer.send(8'h43);
        repeat (3) @(posedge clk);
        chk({31'h0, rts_n}, 32'h1);
        chk({31'h0, dtr_n}, 32'h1);
        pulse(48, 2);
        chk({31'h0, rts_n}, 32'h1);
        pulse(1, 2);
        repeat (3) @(posedge clk);
        chk({31'h0, rts_n}, 32'h0);
        wait_fc(4);
        chk({24'h0, peer.got[2]}, 32'h11);
        chk({24'h0, peer.got[3]}, 32'h91);
        cts <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, halt}, 32'h1);
        cts <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, halt}, 32'h0);
        $display("test flow done");
        wr(`UFC_OFS_EFR, 8'h30);
        wr(`UFC_OFS_ISR, 8'h30);
        peer.send(8'h93);
        rd_chk(`UFC_OFS_ISR, 8'h10);
        rd_chk(`UFC_OFS_RX_FIFO_LEVEL_COUNT, 8'h08);
        $display("test special done");
        test_done();
    end
endmodule
`default_nettype wire
